//--- core/lss_adc_if.sv
// Purpose: carrier between the converter sequencer and the supervisor core.
// Assumes: single clock.
// Notes: one sample pair per conversion.
`timescale 1ns/10ps
interface lss_adc_if;
	logic ac_sel;
	lss_pkg::lss_sample_t ring_sample;
	lss_pkg::lss_sample_t aux_sample;
	logic sample_valid;
	modport seq
	(
		input ac_sel,
		output ring_sample,
		output aux_sample,
		output sample_valid
	);
	modport core
	(
		output ac_sel,
		input ring_sample,
		input aux_sample,
		input sample_valid
	);
endinterface

//--- core/lss_adc_seq.sv
// Purpose: paces the 8-bit auxiliary converter and selects its inputs.
// Assumes: converter codes are synchronous to hclk.
// Notes: one sample_valid pulse per conversion period.
`timescale 1ns/10ps
`include "lss_map.svh"
module lss_adc_seq
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [7:0] ring_sense_pos,
	input wire logic [7:0] ring_sense_neg,
	input wire logic [7:0] line_voltage_input,
	input wire logic [7:0] line_current_input,
	lss_adc_if.seq adc
);
	logic [7:0] cnt_r;
	wire conv_done = (cnt_r == 8'(`LSS_CONV_CYC - 1));
	wire [7:0] ring_diff = (ring_sense_pos >= ring_sense_neg) ?
		8'(ring_sense_pos - ring_sense_neg) :
		8'(ring_sense_neg - ring_sense_pos);
	wire [7:0] first_in = adc.ac_sel ? line_current_input : ring_diff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_r <= 8'h00;
		else
			cnt_r <= conv_done ? 8'h00 : 8'(cnt_r + 8'h01);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			adc.ring_sample <= 8'h00;
			adc.aux_sample <= 8'h00;
			adc.sample_valid <= 1'b0;
		end
		else
		begin
			adc.sample_valid <= conv_done;
			if (conv_done)
			begin
				adc.ring_sample <= first_in;
				adc.aux_sample <= line_voltage_input;
			end
		end
	end
endmodule

//--- core/lss_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
//          of the line status supervisor.
// Assumes: AHB-Lite word registers, 20 MHz hclk.
// Notes: included by the lss_adc_seq and lss_top design files and by the bench.
`ifndef LSS_MAP_SVH
`define LSS_MAP_SVH

`define LSS_CTRL_ADDR 12'h000
`define LSS_CFG_ADDR 12'h004
`define LSS_STAT_ADDR 12'h008
`define LSS_MASK_ADDR 12'h00c
`define LSS_LIVE_ADDR 12'h010
`define LSS_ADC_ADDR 12'h014
`define LSS_THR_ADDR 12'h018

`define LSS_CTRL_RST 32'h0000_0000
`define LSS_CFG_RST 32'h0000_0000
`define LSS_MASK_RST 8'h00
`define LSS_THR_RST 32'h0000_0000

// Control register fields.
`define LSS_C_OFFHOOK_REQ 0
`define LSS_C_LINE_PWR 1
`define LSS_C_AC_TRANS 2
`define LSS_C_LVD_DIS 3
`define LSS_C_MASTER 4
`define LSS_C_UV_EN 5
`define LSS_C_OV_EN 6
`define LSS_C_OC_EN 7
`define LSS_C_CID_MODE 8

// Status bits, same layout in the mask register.
`define LSS_S_RING 0
`define LSS_S_BUSY 1
`define LSS_S_PICKUP 2
`define LSS_S_REVERSAL 3
`define LSS_S_UV 4
`define LSS_S_OV 5
`define LSS_S_OC 6
`define LSS_S_WAKE 7
`define LSS_NSTAT 8

// Default thresholds: busy, pickup delta, ring swing, over-voltage,
// over-current, under-current.
`define LSS_BUSY_LVL 8'h40
`define LSS_PICK_DELTA 8'h10
`define LSS_RING_BASE 8'h20
`define LSS_OV_LVL 8'he0
`define LSS_OC_LVL 8'hf0
`define LSS_UV_LVL 8'h08

// Conversion period of the auxiliary converter.
`define LSS_CONV_NS 1000
`define LSS_CLK_NS 50
`define LSS_CONV_CYC (`LSS_CONV_NS / `LSS_CLK_NS)

`endif

//--- core/lss_pkg.sv
// Purpose: types of the line status supervisor.
// Assumes: nothing.
// Notes: constants live in lss_map.svh.
package lss_pkg;
	typedef enum logic [1:0] {LSS_ONHOOK, LSS_CHECK, LSS_OFFHOOK} lss_hook_t;
	typedef logic [7:0] lss_sample_t;
endpackage

//--- core/lss_top.sv
// Purpose: line status supervisor with AHB-Lite register slave.
// Assumes: single clock hclk at 20 MHz, asynchronous active-low reset.
// Notes: writing one to a status bit clears it; events win over clears.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "lss_map.svh"
module lss_top
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] ring_sense_pos,
	input wire logic [7:0] ring_sense_neg,
	input wire logic [7:0] line_voltage_input,
	input wire logic [7:0] line_current_input,
	input wire logic [7:0] rx_path_in,
	input wire logic [7:0] cid_path_in,
	output logic [7:0] rx_path_out,
	output logic off_hook,
	output logic barrier_powered,
	output logic [1:0] ac_impedance_code,
	output logic [1:0] dc_characteristic_code,
	output logic irq
);
	// ****************************************
	// Bus slave
	// ****************************************
	logic wr_pend_r;
	logic rd_pend_r;
	logic [11:0] addr_r;
	logic [31:0] ctrl_r;
	logic [31:0] cfg_r;
	logic [31:0] thr_r;
	logic [7:0] stat_r;
	logic [7:0] stat_nxt;
	logic [7:0] mask_r;
	logic [31:0] rdata_nxt;

	wire take = hsel & hready & htrans[1];
	wire do_wr = wr_pend_r;
	wire wr_ctrl = do_wr & (addr_r == `LSS_CTRL_ADDR);
	wire wr_cfg = do_wr & (addr_r == `LSS_CFG_ADDR);
	wire wr_stat = do_wr & (addr_r == `LSS_STAT_ADDR);
	wire wr_mask = do_wr & (addr_r == `LSS_MASK_ADDR);
	wire wr_thr = do_wr & (addr_r == `LSS_THR_ADDR);

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 12'h000;
		end
		else
		begin
			wr_pend_r <= take & hwrite;
			rd_pend_r <= take & ~hwrite;
			if (take)
				addr_r <= haddr[11:0];
		end
	end

	// ****************************************
	// Converter
	// ****************************************
	lss_adc_if adc();

	lss_adc_seq u_seq
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.ring_sense_pos(ring_sense_pos),
		.ring_sense_neg(ring_sense_neg),
		.line_voltage_input(line_voltage_input),
		.line_current_input(line_current_input),
		.adc(adc)
	);

	assign adc.ac_sel = ctrl_r[`LSS_C_AC_TRANS];

	// ****************************************
	// Detectors
	// ****************************************
	lss_pkg::lss_hook_t hook_r;
	lss_pkg::lss_hook_t hook_nxt;
	logic [7:0] prev_ring_r;
	logic [7:0] prev_line_r;
	logic polarity_r;
	logic barrier_r;
	logic lvd_dis_r;
	logic samp_pol_r;

	wire [1:0] ring_thr = thr_r[1:0];
	wire [7:0] ring_lvl = 8'(`LSS_RING_BASE * ring_thr);
	wire sv = adc.sample_valid;
	wire [7:0] rs = adc.ring_sample;
	wire [7:0] lv = adc.aux_sample;
	wire master = ctrl_r[`LSS_C_MASTER] & ~lvd_dis_r;
	wire uv_en = master & ctrl_r[`LSS_C_UV_EN];
	wire ov_en = master & ctrl_r[`LSS_C_OV_EN];
	wire oc_en = master & ctrl_r[`LSS_C_OC_EN];
	wire ring_in = ~adc.ac_sel;
	// A polarity flip swings the pair through zero, so the step is the sum.
	wire flip = samp_pol_r != polarity_r;
	wire [8:0] swing_sum = {1'b0, rs} + {1'b0, prev_ring_r};
	wire [7:0] swing = swing_sum[8] ? 8'hff : swing_sum[7:0];
	wire [7:0] jump = flip ? swing : (rs >= prev_ring_r) ?
		8'(rs - prev_ring_r) : 8'(prev_ring_r - rs);
	wire wake_ev = sv & ring_in & (jump >= ring_lvl) & (ring_thr != 2'b00);
	wire ring_ev = wake_ev & (rs >= ring_lvl);
	wire cur_pol = ring_sense_pos >= ring_sense_neg;
	wire rev_ev = wake_ev & (hook_r == lss_pkg::LSS_ONHOOK) &
		flip;
	wire busy_lvl = lv < `LSS_BUSY_LVL;
	wire busy_ev = sv & (hook_r == lss_pkg::LSS_CHECK) & busy_lvl;
	// parallel pickup drops the off-hook voltage.
	wire pick_ev = sv & (hook_r == lss_pkg::LSS_OFFHOOK) &
		(prev_line_r > lv) & (8'(prev_line_r - lv) >= `LSS_PICK_DELTA);
	// under-voltage when current cannot be supplied.
	wire uv_ev = sv & uv_en & adc.ac_sel & (rs < `LSS_UV_LVL) &
		(hook_r == lss_pkg::LSS_OFFHOOK);
	wire ov_ev = sv & ov_en & (lv >= `LSS_OV_LVL);
	wire oc_ev = sv & oc_en & adc.ac_sel & (rs >= `LSS_OC_LVL);
	wire [7:0] events = {wake_ev, oc_ev, ov_ev, uv_ev, rev_ev, pick_ev,
		busy_ev, ring_ev};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prev_ring_r <= 8'h00;
			prev_line_r <= 8'h00;
			polarity_r <= 1'b1;
		end
		else if (sv)
		begin
			prev_ring_r <= rs;
			prev_line_r <= lv;
			polarity_r <= samp_pol_r;
		end
	end

	// Pin polarity lined up with the sample taken at the same edge.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			samp_pol_r <= 1'b1;
		else
			samp_pol_r <= cur_pol;
	end

	// ****************************************
	// Hook state
	// ****************************************
	always_comb
	begin
		hook_nxt = hook_r;
		case (hook_r)
			lss_pkg::LSS_ONHOOK:
				if (ctrl_r[`LSS_C_OFFHOOK_REQ])
					hook_nxt = lss_pkg::LSS_CHECK;
			lss_pkg::LSS_CHECK:
				if (!ctrl_r[`LSS_C_OFFHOOK_REQ])
					hook_nxt = lss_pkg::LSS_ONHOOK;
				else if (sv && !busy_lvl)
					hook_nxt = lss_pkg::LSS_OFFHOOK;
			lss_pkg::LSS_OFFHOOK:
				if (!ctrl_r[`LSS_C_OFFHOOK_REQ])
					hook_nxt = lss_pkg::LSS_ONHOOK;
			default:
				hook_nxt = lss_pkg::LSS_ONHOOK;
		endcase
		if (ov_ev || oc_ev)
			hook_nxt = lss_pkg::LSS_ONHOOK;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hook_r <= lss_pkg::LSS_ONHOOK;
		else
			hook_r <= hook_nxt;
	end

	// ****************************************
	// Power source and level detect disable
	// ****************************************
	wire line_pwr_set = wr_ctrl & hwdata[`LSS_C_LINE_PWR];
	wire irq_any = |(stat_r & mask_r);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			barrier_r <= 1'b1;
		// under-voltage falls back to barrier power.
		else if (uv_ev)
			barrier_r <= 1'b1;
		else if (wr_ctrl)
			barrier_r <= ~hwdata[`LSS_C_LINE_PWR];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			lvd_dis_r <= 1'b0;
		// set on interrupt, cleared on line power entry.
		else if (irq_any)
			lvd_dis_r <= 1'b1;
		else if (line_pwr_set)
			lvd_dis_r <= 1'b0;
		else if (wr_ctrl)
			lvd_dis_r <= hwdata[`LSS_C_LVD_DIS];
	end

	// ****************************************
	// Registers
	// ****************************************
	// sticky flags, set wins over clear.
	assign stat_nxt = (stat_r & ~(wr_stat ? hwdata[7:0] : 8'h00)) | events;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_r <= `LSS_CTRL_RST;
			cfg_r <= `LSS_CFG_RST;
			thr_r <= `LSS_THR_RST;
			mask_r <= `LSS_MASK_RST;
			stat_r <= 8'h00;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= {23'h0, hwdata[8:0]};
			else if (ov_ev || oc_ev)
				ctrl_r[`LSS_C_OFFHOOK_REQ] <= 1'b0;
			// country codes held for the front end.
			if (wr_cfg)
				cfg_r <= {28'h0000000, hwdata[3:0]};
			if (wr_thr)
				thr_r <= {30'h0, hwdata[1:0]};
			if (wr_mask)
				mask_r <= hwdata[7:0];
			stat_r <= stat_nxt;
		end
	end

	wire [31:0] ctrl_view = {ctrl_r[31:4], lvd_dis_r, ctrl_r[2:0]};
	wire [31:0] live_view = {23'h0, barrier_r, polarity_r,
		5'h00, 2'(hook_r)};
	wire [31:0] adc_view = {16'h0000, lv, rs};

	always_comb
	begin
		case (addr_r)
			`LSS_CTRL_ADDR: rdata_nxt = ctrl_view;
			`LSS_CFG_ADDR: rdata_nxt = cfg_r;
			`LSS_STAT_ADDR: rdata_nxt = {24'h000000, stat_r};
			`LSS_MASK_ADDR: rdata_nxt = {24'h000000, mask_r};
			`LSS_LIVE_ADDR: rdata_nxt = live_view;
			`LSS_ADC_ADDR: rdata_nxt = adc_view;
			`LSS_THR_ADDR: rdata_nxt = thr_r;
			default: rdata_nxt = 32'h00000000;
		endcase
	end

	assign hrdata = rd_pend_r ? rdata_nxt : 32'h00000000;

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rx_path_out <= 8'h00;
		// normal receive path carries in-band caller ID off-hook.
		else if (ctrl_r[`LSS_C_CID_MODE] && hook_r != lss_pkg::LSS_OFFHOOK)
			rx_path_out <= cid_path_in;
		else
			rx_path_out <= rx_path_in;
	end

	assign off_hook = (hook_r == lss_pkg::LSS_OFFHOOK);
	assign barrier_powered = barrier_r;
	assign ac_impedance_code = cfg_r[1:0];
	assign dc_characteristic_code = cfg_r[3:2];
	assign irq = irq_any;

	// ****************************************
	// Checks
	// ****************************************
	a_prot_onhook: assert property (@(posedge hclk) disable iff (!hresetn)
		(ov_ev | oc_ev) |=> !off_hook)
		else $error("protection event did not force on-hook");
	a_uv_barrier: assert property (@(posedge hclk) disable iff (!hresetn)
		uv_ev |=> barrier_powered)
		else $error("under-voltage did not select barrier power");
	a_ring_thr_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(ring_thr == 2'b00) |-> !ring_ev)
		else $error("ring event with zero threshold");
	a_master_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!master |-> !(uv_ev | ov_ev | oc_ev))
		else $error("detector active without master enable");
	a_rev_onhook: assert property (@(posedge hclk) disable iff (!hresetn)
		rev_ev |-> hook_r == lss_pkg::LSS_ONHOOK)
		else $error("reversal reported off-hook");
	a_stat_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		events[0] |=> stat_r[0])
		else $error("ring flag not set");
	a_lvd_on_irq: assert property (@(posedge hclk) disable iff (!hresetn)
		irq |=> lvd_dis_r)
		else $error("level detect not disabled by interrupt");
	a_busy_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(hook_r == lss_pkg::LSS_CHECK && sv && busy_lvl) |=> !off_hook)
		else $error("went off-hook on a busy line");
	a_wake_flip: assert property (@(posedge hclk) disable iff (!hresetn)
		(sv && ring_in && ring_thr != 2'b00 && samp_pol_r != polarity_r &&
		rs >= ring_lvl) |-> wake_ev)
		else $error("polarity flip gave no wake-up");
	a_hook_order: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(off_hook) |-> $past(hook_r) == lss_pkg::LSS_CHECK)
		else $error("went off-hook without a line check");
endmodule

//--- verif/line_status_supervisor_tb.sv
// Purpose: self-checking bench of the line status supervisor.
// Assumes: zero wait AHB-Lite slave, 20 MHz hclk.
// Notes: random values come from seed 87.
`timescale 1ns/10ps
`include "lss_map.svh"
module line_status_supervisor_tb;
	logic hclk, hresetn, hsel, hwrite, ringing;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, ac_impedance_code, dc_characteristic_code;
	logic [2:0] hsize;
	logic [7:0] ring_sense_pos, ring_sense_neg, line_voltage_input;
	logic [7:0] line_current_input, rx_path_in, cid_path_in, rx_path_out;
	logic [7:0] volt, curr;
	logic hreadyout, hresp, off_hook, barrier_powered, irq;
	wire hready = hreadyout;
	int n_mismatch = 0;
	int checked = 0;
	logic [31:0] ra [6] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h18, 32'h1c};
	logic [3:0] codes [6] = '{4'h8, 4'h9, 4'hb, 4'hf, 4'h0, 4'h0};

	lss_top u_lss_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.ring_sense_pos, .ring_sense_neg, .line_voltage_input,
		.line_current_input, .rx_path_in, .cid_path_in, .rx_path_out,
		.off_hook, .barrier_powered, .ac_impedance_code,
		.dc_characteristic_code, .irq);
	lss_line_model u_lss_line_model (.hclk, .ringing, .volt, .curr,
		.ring_sense_pos, .ring_sense_neg, .line_voltage_input,
		.line_current_input);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] sb(input int b);
		return 32'h1 << b;
	endfunction

	function automatic logic [7:0] exp_rx(input logic cid, hook,
		input logic [7:0] r, c);
		return (cid && !hook) ? c : r;
	endfunction

	task automatic check(input logic [31:0] got, exp, input string m);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task automatic test_done;
		$display("mismatches %0d, checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic xfer(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [31:0] a, k, e, input string m);
		xfer(1'b0, a, 32'h0);
		check(rd & k, e, m);
	endtask

	task automatic wait_reg(input logic [31:0] a, k, e, input string m);
		for (int i = 0; i < 100; i++)
		begin
			xfer(1'b0, a, 32'h0);
			if ((rd & k) === e)
				break;
		end
		check(rd & k, e, m);
	endtask

	task automatic path_chk(input logic cid, hook);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge hclk);
			rx_path_in <= 8'($urandom);
			cid_path_in <= 8'($urandom);
			repeat (2) @(posedge hclk);
			check(rx_path_out, exp_rx(cid, hook, rx_path_in, cid_path_in),
				"receive path");
		end
	endtask

	// ****************************************
	// Stimulus
	// ****************************************
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	initial
	begin
		repeat (60000) @(posedge hclk);
		n_mismatch++;
		$display("unexpected at %0t: timeout", $time);
		test_done();
	end

	initial
	begin
		{hresetn, hsel, hwrite, ringing, haddr, hwdata, htrans} = '0;
		{rx_path_in, cid_path_in} = '0;
		hsize = 3'b010;
		volt = 8'h80;
		curr = 8'h40;
		void'($urandom(87));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b1, 32'h1c, 32'hffff_ffff);
		for (int i = 0; i < 6; i++)
			rdchk(ra[i], 32'hffff_ffff, 32'h0, "reset value");
		check({off_hook, barrier_powered, irq}, 3'b010, "reset pins");
		codes[5] = 4'($urandom);
		for (int i = 0; i < 6; i++)
		begin
			xfer(1'b1, `LSS_CFG_ADDR, {28'h0, codes[i]});
			@(posedge hclk);
			check({dc_characteristic_code, ac_impedance_code}, codes[i],
				"codes");
		end
		xfer(1'b1, `LSS_CTRL_ADDR, sb(`LSS_C_CID_MODE));
		path_chk(1'b1, 1'b0);
		xfer(1'b1, `LSS_THR_ADDR, 32'h0);
		ringing <= 1'b1;
		repeat (400) @(posedge hclk);
		rdchk(`LSS_STAT_ADDR, sb(`LSS_S_RING), 32'h0, "ring off");
		xfer(1'b1, `LSS_THR_ADDR, $urandom_range(3, 1));
		wait_reg(`LSS_STAT_ADDR, sb(0), sb(0), "ring");
		wait_reg(`LSS_STAT_ADDR, sb(7), sb(7), "wake");
		wait_reg(`LSS_STAT_ADDR, sb(3), sb(3), "reversal");
		ringing <= 1'b0;
		repeat (250) @(posedge hclk);
		rdchk(`LSS_STAT_ADDR, sb(0), sb(0), "sticky ring");
		xfer(1'b1, `LSS_STAT_ADDR, 32'hff);
		rdchk(`LSS_STAT_ADDR, 32'hff, 32'h0, "clear");
		volt <= 8'h10;
		xfer(1'b1, `LSS_CTRL_ADDR, 32'h101);
		wait_reg(`LSS_STAT_ADDR, sb(1), sb(1), "busy");
		check(off_hook, 1'b0, "held on-hook");
		volt <= 8'h80;
		wait_reg(`LSS_LIVE_ADDR, 32'h3, 32'h2, "seized");
		check(off_hook, 1'b1, "off-hook");
		path_chk(1'b1, 1'b1);
		volt <= 8'h50;
		wait_reg(`LSS_STAT_ADDR, sb(2), sb(2), "pickup");
		xfer(1'b1, `LSS_CTRL_ADDR, 32'h41);
		volt <= 8'hf0;
		repeat (200) @(posedge hclk);
		check(off_hook, 1'b1, "no master");
		rdchk(`LSS_STAT_ADDR, sb(5), 32'h0, "no master flag");
		xfer(1'b1, `LSS_CTRL_ADDR, 32'h51);
		wait_reg(`LSS_STAT_ADDR, sb(5), sb(5), "over-voltage");
		repeat (2) @(posedge hclk);
		check(off_hook, 1'b0, "forced on-hook");
		volt <= 8'h80;
		xfer(1'b1, `LSS_STAT_ADDR, 32'hff);
		xfer(1'b1, `LSS_MASK_ADDR, sb(4));
		xfer(1'b1, `LSS_CTRL_ADDR, 32'h37);
		curr <= 8'h5a;
		repeat (60) @(posedge hclk);
		check(barrier_powered, 1'b0, "line power");
		rdchk(`LSS_ADC_ADDR, 32'hffff, 32'h805a, "converter");
		curr <= 8'h00;
		wait_reg(`LSS_STAT_ADDR, sb(4), sb(4), "under-voltage");
		repeat (2) @(posedge hclk);
		check({barrier_powered, irq}, 2'b11, "barrier irq");
		rdchk(`LSS_CTRL_ADDR, sb(3), sb(3), "detect off");
		xfer(1'b1, `LSS_MASK_ADDR, 32'h0);
		@(posedge hclk);
		check(irq, 1'b0, "masked");
		xfer(1'b1, `LSS_CTRL_ADDR, 32'h10);
		rdchk(`LSS_CTRL_ADDR, sb(3), 32'h0, "detect on");
		curr <= 8'h40;
		repeat (60) @(posedge hclk);
		xfer(1'b1, `LSS_MASK_ADDR, sb(4));
		xfer(1'b1, `LSS_STAT_ADDR, 32'hff);
		@(posedge hclk);
		check(irq, 1'b0, "cleared");
		curr <= 8'hf8;
		xfer(1'b1, `LSS_CTRL_ADDR, 32'h97);
		wait_reg(`LSS_STAT_ADDR, sb(6), sb(6), "over-current");
		rdchk(`LSS_CTRL_ADDR, sb(0), 32'h0, "request dropped");
		check(off_hook, 1'b0, "over-current on-hook");
		test_done();
	end
endmodule

//--- verif/lss_line_model.sv
// Purpose: line side model driving the converter codes of the block.
// Assumes: codes change just after hclk rises.
// Notes: ringing swaps the ring-sense pair every 100 cycles.
`timescale 1ns/10ps
module lss_line_model
(
	input wire logic hclk,
	input wire logic ringing,
	input wire logic [7:0] volt,
	input wire logic [7:0] curr,
	output logic [7:0] ring_sense_pos,
	output logic [7:0] ring_sense_neg,
	output logic [7:0] line_voltage_input,
	output logic [7:0] line_current_input
);
	int n = 0;
	logic phase = 1'b0;

	// raw bursts only.
	// The bursts carry no cadence check; judging them is left to the host.
	always @(posedge hclk)
	begin
		n <= (n == 99) ? 0 : n + 1;
		if (!ringing)
		begin
			ring_sense_pos <= 8'h60;
			ring_sense_neg <= 8'h60;
		end
		else if (n == 99)
		begin
			phase <= !phase;
			ring_sense_pos <= phase ? 8'hc0 : 8'h00;
			ring_sense_neg <= phase ? 8'h00 : 8'hc0;
		end
		line_voltage_input <= volt;
		line_current_input <= curr;
	end
endmodule
